// >>> rtl/dslas_central.sv
/*
 * Central end of the activation sequencer: backoff choice, reply
 * signal timing, timeouts and exception handling.
 * Assumes a scrambler downstream of link.c_bit and a synchronous clock.
 */
// Functional notes
// - both ends select and exchange backoff value
// - loss equals transmit minus estimated receive power
// - backoff between band default and 31 dB
// - default backoff 0 to 6 by band
// - one bit per symbol, two-level
// - all-ones source feeds scrambler
// - four-wire: user data after both pairs
// - preactivation plus activation within 30 s
// - remote first signal 0.3 s, lasts beta
// - remote first signal all-ones, upstream mask
// - central reply all-ones after remote signal
// - reply starts 500 ms after remote end
// - remote second signal 1.5 beta later
// - at most 15 beta to data
// - payload valid within 1 s
// - silent 2 s after exception
// - remote lock within 5 s of reply
// - beta 1 above n 12, else 2
// - unconverged reply enters exception
// - exception: silence, far quiet, preactivate
// - timeouts or abnormal events cause exception
`timescale 1ns/1ps
`default_nettype none

module dslas_central
    import dslas_pkg::*;
#(
    parameter dslas_cnt_t P_CRSC    = CRSC_CYC,
    parameter dslas_cnt_t P_PLL     = PLL_CYC,
    parameter dslas_cnt_t P_SILENCE = SILENCE_CYC,
    parameter dslas_cnt_t P_BETA    = BETA_CYC,
    parameter dslas_cnt_t P_GLOBAL  = GLOBAL_CYC,
    parameter dslas_cnt_t P_PAYLOAD = PAYLOAD_CYC
) (
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    input  wire logic              start_i,
    input  wire logic              preact_done_i,
    input  wire logic signed [7:0] tx_dbm_i,
    input  wire logic signed [7:0] rx_est_dbm_i,
    input  wire logic [4:0]        pbo_req_i,
    input  wire logic [5:0]        rate_mult_i,
    input  wire logic              converged_i,
    input  wire logic              abnormal_i,
    input  wire logic              framer_sync_i,
    input  wire logic              four_wire_i,
    input  wire logic              other_pair_done_i,
    input  wire logic              user_bit_i,
    dslas_link_if.central          link,
    output logic [2:0]             state_o,
    output logic [4:0]             pbo_o,
    output logic [4:0]             far_pbo_o,
    output logic                   data_mode_o,
    output logic                   user_data_en_o,
    output logic                   payload_valid_o,
    output logic                   exception_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dslas_cst_t state_r;
    dslas_cst_t state_nxt;
    dslas_cnt_t ph_r;
    dslas_cnt_t act_r;
    dslas_cnt_t glb_r;
    dslas_cnt_t unit;
    dslas_cnt_t act_lim;
    logic [4:0] pbo_r;
    logic [4:0] far_pbo_r;
    logic       tx_on_r;
    logic       tx_bit_r;
    logic       pv_r;
    logic       in_train;
    logic       in_core;
    logic       fault;
    logic       both_pairs;

    // ------------------------------------------------------------
    // Scaled limits
    // ------------------------------------------------------------
    assign unit       = (rate_mult_i > BETA_N_LIM) ? P_BETA : (P_BETA << 1);
    assign act_lim    = dslas_cnt_t'(unit * ACT_BETAS);
    assign in_train   = (state_r == CS_PREACT) || in_core;
    assign in_core    = (state_r == CS_WAIT_CR) || (state_r == CS_CR_ON)
                     || (state_r == CS_GAP) || (state_r == CS_SC);
    assign both_pairs = !four_wire_i || other_pair_done_i;

    always_comb begin
        fault = 1'b0;
        if (in_train) begin
            fault = abnormal_i || (glb_r >= P_GLOBAL - 1);
            if (state_r != CS_PREACT && state_r != CS_WAIT_CR
                && act_r >= act_lim - 1)
                fault = 1'b1;
        end else if (state_r == CS_DATA) begin
            fault = abnormal_i || (!framer_sync_i && ph_r >= P_PAYLOAD - 1);
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CS_IDLE: begin
                if (start_i)
                    state_nxt = CS_PREACT;
            end
            CS_PREACT: begin
                if (preact_done_i)
                    state_nxt = CS_WAIT_CR;
            end
            CS_WAIT_CR: begin
                if (link.r_on)
                    state_nxt = CS_CR_ON;
            end
            CS_CR_ON: begin
                if (!link.r_on)
                    state_nxt = CS_GAP;
            end
            CS_GAP: begin
                if (ph_r >= P_CRSC - 1)
                    state_nxt = CS_SC;
            end
            CS_SC: begin
                if (ph_r >= P_PLL - 1)
                    state_nxt = converged_i ? CS_DATA : CS_EXCEPT;
            end
            CS_DATA: begin
                state_nxt = CS_DATA;
            end
            CS_EXCEPT: begin
                if (ph_r >= P_SILENCE - 1 && !link.r_on)
                    state_nxt = CS_PREACT;
            end
            default: begin
                state_nxt = CS_IDLE;
            end
        endcase
        if (fault)
            state_nxt = CS_EXCEPT;
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i)
            state_r <= CS_IDLE;
        else if (ce_i)
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------
    // Interval timers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i)
            ph_r <= '0;
        else if (ce_i) begin
            if (state_nxt != state_r)
                ph_r <= '0;
            else if (ph_r != '1)
                ph_r <= ph_r + 36'h0_0000_0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i)
            act_r <= '0;
        else if (ce_i) begin
            if (state_nxt == CS_CR_ON && state_r == CS_WAIT_CR)
                act_r <= '0;
            else if (in_core)
                act_r <= act_r + 36'h0_0000_0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i)
            glb_r <= '0;
        else if (ce_i) begin
            if (state_nxt == CS_PREACT && state_r != CS_PREACT)
                glb_r <= '0;
            else if (in_train)
                glb_r <= glb_r + 36'h0_0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Backoff choice and exchange
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pbo_r     <= PBO_DFLT_LO;
            far_pbo_r <= PBO_NONE;
        end else if (ce_i && state_r == CS_PREACT) begin
            pbo_r <= dslas_pbo_sel(tx_dbm_i, rx_est_dbm_i, pbo_req_i);
            if (preact_done_i)
                far_pbo_r <= link.r_pbo;
        end
    end

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            tx_on_r  <= 1'b0;
            tx_bit_r <= 1'b0;
        end else if (ce_i) begin
            tx_on_r <= (state_nxt == CS_SC) || (state_nxt == CS_DATA);
            if (state_nxt == CS_SC)
                tx_bit_r <= 1'b1;
            else if (state_nxt == CS_DATA)
                tx_bit_r <= user_bit_i && both_pairs;
            else
                tx_bit_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i)
            pv_r <= 1'b0;
        else if (ce_i)
            pv_r <= (state_nxt == CS_DATA) && framer_sync_i;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.c_on       = tx_on_r;
    assign link.c_bit      = tx_bit_r;
    assign link.c_pbo      = pbo_r;
    assign state_o         = state_r;
    assign pbo_o           = pbo_r;
    assign far_pbo_o       = far_pbo_r;
    assign data_mode_o     = (state_r == CS_DATA);
    assign user_data_en_o  = (state_r == CS_DATA) && both_pairs;
    assign payload_valid_o = pv_r;
    assign exception_o     = (state_r == CS_EXCEPT);

endmodule // dslas_central

`default_nettype wire

// >>> rtl/dslas_link_if.sv
/*
 * Loop-side link between the central and remote ends.
 * Assumes both ends share core_clk; the bench joins the two modports.
 */
`timescale 1ns/1ps
`default_nettype none

interface dslas_link_if;
    logic       c_on;
    logic       c_bit;
    logic [4:0] c_pbo;
    logic       r_on;
    logic       r_bit;
    logic [4:0] r_pbo;

    modport central (output c_on, output c_bit, output c_pbo,
                     input r_on, input r_bit, input r_pbo);
    modport remote  (output r_on, output r_bit, output r_pbo,
                     input c_on, input c_bit, input c_pbo);
endinterface

`default_nettype wire

// >>> rtl/dslas_pkg.sv
/*
 * Shared constants, state encodings and the backoff selector for the
 * activation sequencer ends.
 * Assumes a single 200 MHz core clock on both ends.
 */
package dslas_pkg;

    // ------------------------------------------------------------
    // Timing figures
    // ------------------------------------------------------------
    typedef logic [35:0] dslas_cnt_t;

    localparam longint CLK_HZ          = 200000000;
    localparam longint CYC_PER_MS      = CLK_HZ / 1000;
    localparam longint T_PREGAP_MS     = 300;
    localparam longint T_BETA_UNIT_MS  = 1000;
    localparam longint T_CRSC_MS       = 500;
    localparam longint T_PLL_MS        = 5000;
    localparam longint T_SILENCE_MS    = 2000;
    localparam longint T_PAYLOAD_MS    = 1000;
    localparam longint T_GLOBAL_MS     = 30000;

    localparam dslas_cnt_t PREGAP_CYC  = dslas_cnt_t'(T_PREGAP_MS * CYC_PER_MS);
    localparam dslas_cnt_t BETA_CYC    = dslas_cnt_t'(T_BETA_UNIT_MS * CYC_PER_MS);
    localparam dslas_cnt_t CRSC_CYC    = dslas_cnt_t'(T_CRSC_MS * CYC_PER_MS);
    localparam dslas_cnt_t PLL_CYC     = dslas_cnt_t'(T_PLL_MS * CYC_PER_MS);
    localparam dslas_cnt_t SILENCE_CYC = dslas_cnt_t'(T_SILENCE_MS * CYC_PER_MS);
    localparam dslas_cnt_t PAYLOAD_CYC = dslas_cnt_t'(T_PAYLOAD_MS * CYC_PER_MS);
    localparam dslas_cnt_t GLOBAL_CYC  = dslas_cnt_t'(T_GLOBAL_MS * CYC_PER_MS);
    localparam logic [3:0] ACT_BETAS   = 4'hF;
    localparam logic [5:0] BETA_N_LIM  = 6'h0C;

    // ------------------------------------------------------------
    // Backoff
    // ------------------------------------------------------------
    localparam logic [4:0] PBO_MAX     = 5'h1F;
    localparam logic [4:0] PBO_DFLT_LO = 5'h06;
    localparam logic [4:0] PBO_NONE    = 5'h00;

    // Width of the result bounds it at the maximum backoff
    function automatic logic [4:0] dslas_pbo_sel(
        input logic signed [7:0] tx_dbm,
        input logic signed [7:0] rx_dbm,
        input logic [4:0]        req);
        logic signed [8:0] loss;
        logic [4:0]        dflt;
        loss = $signed({tx_dbm[7], tx_dbm}) - $signed({rx_dbm[7], rx_dbm});
        if (loss > 9'sh006)
            dflt = PBO_NONE;
        else if (loss < 9'sh001)
            dflt = PBO_DFLT_LO;
        else
            dflt = 5'(9'sh007 - loss);
        return (req > dflt) ? req : dflt;
    endfunction

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_IDLE = 3'h0, CS_PREACT = 3'h1, CS_WAIT_CR = 3'h3, CS_CR_ON = 3'h2,
        CS_GAP  = 3'h6, CS_SC     = 3'h7, CS_DATA    = 3'h5, CS_EXCEPT = 3'h4
    } dslas_cst_t;

    typedef enum logic [2:0] {
        RS_IDLE = 3'h0, RS_PREACT = 3'h1, RS_PREGAP = 3'h3, RS_CR   = 3'h2,
        RS_WAIT = 3'h6, RS_SR     = 3'h7, RS_DATA   = 3'h5, RS_EXCEPT = 3'h4
    } dslas_rst_t;

endpackage

// >>> rtl/dslas_remote.sv
/*
 * Remote end of the activation sequencer: first and second signal
 * timing, lock supervision, timeouts and exception handling.
 * Assumes a scrambler downstream of link.r_bit and a synchronous clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dslas_remote
    import dslas_pkg::*;
#(
    parameter dslas_cnt_t P_PREGAP  = PREGAP_CYC,
    parameter dslas_cnt_t P_BETA    = BETA_CYC,
    parameter dslas_cnt_t P_PLL     = PLL_CYC,
    parameter dslas_cnt_t P_SILENCE = SILENCE_CYC,
    parameter dslas_cnt_t P_GLOBAL  = GLOBAL_CYC,
    parameter dslas_cnt_t P_PAYLOAD = PAYLOAD_CYC
) (
    input  wire logic              core_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    input  wire logic              start_i,
    input  wire logic              preact_done_i,
    input  wire logic signed [7:0] tx_dbm_i,
    input  wire logic signed [7:0] rx_est_dbm_i,
    input  wire logic [4:0]        pbo_req_i,
    input  wire logic [5:0]        rate_mult_i,
    input  wire logic              lock_i,
    input  wire logic              abnormal_i,
    input  wire logic              framer_sync_i,
    input  wire logic              four_wire_i,
    input  wire logic              other_pair_done_i,
    input  wire logic              user_bit_i,
    dslas_link_if.remote           link,
    output logic [2:0]             state_o,
    output logic [4:0]             pbo_o,
    output logic [4:0]             far_pbo_o,
    output logic                   data_mode_o,
    output logic                   user_data_en_o,
    output logic                   payload_valid_o,
    output logic                   exception_o
);

    dslas_rst_t state_r;
    dslas_rst_t state_nxt;
    dslas_cnt_t ph_r;
    dslas_cnt_t act_r;
    dslas_cnt_t glb_r;
    dslas_cnt_t pll_r;
    dslas_cnt_t unit;
    logic       c_seen_r;
    logic [4:0] pbo_r;
    logic [4:0] far_pbo_r;
    logic       tx_on_r;
    logic       tx_bit_r;
    logic       pv_r;
    logic       in_core;
    logic       fault;
    logic       both_pairs;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign unit       = (rate_mult_i > BETA_N_LIM) ? P_BETA : (P_BETA << 1);
    assign in_core    = (state_r == RS_PREGAP) || (state_r == RS_CR)
                     || (state_r == RS_WAIT) || (state_r == RS_SR);
    assign both_pairs = !four_wire_i || other_pair_done_i;

    always_comb begin
        fault = 1'b0;
        if (in_core || state_r == RS_PREACT)
            fault = abnormal_i || (glb_r >= P_GLOBAL - 1)
                 || (c_seen_r && pll_r >= P_PLL - 1)
                 || (state_r != RS_PREACT && state_r != RS_PREGAP
                     && act_r >= dslas_cnt_t'(unit * ACT_BETAS) - 1);
        else if (state_r == RS_DATA)
            fault = abnormal_i || (!framer_sync_i && ph_r >= P_PAYLOAD - 1);
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RS_IDLE:   if (start_i) state_nxt = RS_PREACT;
            RS_PREACT: if (preact_done_i) state_nxt = RS_PREGAP;
            RS_PREGAP: if (ph_r >= P_PREGAP - 1) state_nxt = RS_CR;
            RS_CR:     if (ph_r >= unit - 1) state_nxt = RS_WAIT;
            RS_WAIT:   if (ph_r >= unit + (unit >> 1) - 1) state_nxt = RS_SR;
            RS_SR:     if (c_seen_r && lock_i) state_nxt = RS_DATA;
            RS_DATA:   state_nxt = RS_DATA;
            RS_EXCEPT: if (ph_r >= P_SILENCE - 1 && !link.c_on)
                           state_nxt = RS_PREACT;
            default:   state_nxt = RS_IDLE;
        endcase
        if (fault)
            state_nxt = RS_EXCEPT;
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i)
            state_r <= RS_IDLE;
        else if (ce_i)
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------
    // Interval timers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ph_r  <= '0;
            act_r <= '0;
            glb_r <= '0;
        end else if (ce_i) begin
            ph_r  <= (state_nxt != state_r) ? '0
                   : (ph_r != '1) ? ph_r + 36'h0_0000_0001 : ph_r;
            act_r <= (state_r != RS_CR && state_nxt == RS_CR) ? '0
                   : act_r + 36'h0_0000_0001;
            glb_r <= (state_r != RS_PREACT && state_nxt == RS_PREACT) ? '0
                   : glb_r + 36'h0_0000_0001;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            c_seen_r <= 1'b0;
            pll_r    <= '0;
        end else if (ce_i) begin
            if (!in_core) begin
                c_seen_r <= 1'b0;
                pll_r    <= '0;
            end else if (link.c_on) begin
                c_seen_r <= 1'b1;
            end
            if (in_core && c_seen_r)
                pll_r <= pll_r + 36'h0_0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Backoff, transmit and outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pbo_r     <= PBO_DFLT_LO;
            far_pbo_r <= PBO_NONE;
        end else if (ce_i && state_r == RS_PREACT) begin
            pbo_r <= dslas_pbo_sel(tx_dbm_i, rx_est_dbm_i, pbo_req_i);
            if (preact_done_i)
                far_pbo_r <= link.c_pbo;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            tx_on_r  <= 1'b0;
            tx_bit_r <= 1'b0;
            pv_r     <= 1'b0;
        end else if (ce_i) begin
            tx_on_r  <= (state_nxt == RS_CR) || (state_nxt == RS_SR)
                     || (state_nxt == RS_DATA);
            tx_bit_r <= (state_nxt == RS_CR) || (state_nxt == RS_SR)
                     || (state_nxt == RS_DATA && user_bit_i && both_pairs);
            pv_r     <= (state_nxt == RS_DATA) && framer_sync_i;
        end
    end

    assign link.r_on       = tx_on_r;
    assign link.r_bit      = tx_bit_r;
    assign link.r_pbo      = pbo_r;
    assign state_o         = state_r;
    assign pbo_o           = pbo_r;
    assign far_pbo_o       = far_pbo_r;
    assign data_mode_o     = (state_r == RS_DATA);
    assign user_data_en_o  = (state_r == RS_DATA) && both_pairs;
    assign payload_valid_o = pv_r;
    assign exception_o     = (state_r == RS_EXCEPT);

endmodule // dslas_remote

`default_nettype wire

// >>> verif/dslas_chk.sv
/* Link checker for the two sequencer ends.
   Assumes ce_i held high and the bench's short timer parameters. */
`timescale 1ns/1ps
`default_nettype none
module dslas_chk (
    input wire logic       core_clk_i,
    input wire logic       reset_n_i,
    input wire logic       c_on,
    input wire logic       c_bit,
    input wire logic [4:0] c_pbo,
    input wire logic       r_on,
    input wire logic       r_bit,
    input wire logic [4:0] r_pbo
);
    int unsigned r_run_r;
    int unsigned c_run_r;

    always_ff @(posedge core_clk_i) begin
        r_run_r <= r_on ? r_run_r + 1 : 0;
    end

    always_ff @(posedge core_clk_i) begin
        c_run_r <= c_on ? c_run_r + 1 : 0;
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence cr_end;
        $fell(r_on) && !c_on && !$past(c_on);
    endsequence
    sequence sc_start;
        $rose(c_on);
    endsequence

    cr_len_a: assert property (cr_end |-> r_run_r inside {20, 40})
        else $error("first remote signal length off");
    crsc_gap_a: assert property (cr_end |-> ##[9:12] sc_start)
        else $error("central reply start off");
    crsr_gap_a: assert property (cr_end |-> ##[29:62] $rose(r_on))
        else $error("remote second signal start off");
    r_ones_a: assert property ($rose(r_on) |-> r_bit)
        else $error("remote signal not all ones");
    c_ones_a: assert property (sc_start |-> c_bit)
        else $error("central reply not all ones");
    sc_len_a: assert property ($fell(c_on) |-> c_run_r >= 60)
        else $error("central reply cut short");
    sc_order_a: assert property (sc_start |-> !r_on)
        else $error("central reply overlaps remote signal");
    c_pbo_a: assert property (c_on |-> $stable(c_pbo))
        else $error("central backoff moved while sending");
    r_pbo_a: assert property (r_on |-> $stable(r_pbo))
        else $error("remote backoff moved while sending");
endmodule // dslas_chk
`default_nettype wire

// >>> verif/test_dsl_activation_sequencer.sv
/* Bench joining both sequencer ends over the link interface.
   Assumes the package, interface, both ends and the checker. */
`timescale 1ns/1ps
`default_nettype none
module test_dsl_activation_sequencer;
    import dslas_pkg::*;
    logic core_clk_i, reset_n_i, start_i, pd_i, conv_i, lock_i, fs_i, fw_i, opd_i, ub_i, ab_i;
    logic signed [7:0] c_tx, c_rx, r_tx, r_rx;
    logic [4:0]        c_rq, r_rq, c_pbo, c_fp, r_pbo, r_fp;
    logic [5:0]        rate;
    logic [2:0]        c_st, r_st;
    logic              c_dm, c_ue, c_pv, c_ex, r_dm, r_ue, r_pv, r_ex;
    logic              ce_i;
    logic [31:0]       seed;
    int                error_cnt, n_checks, cyc, t, u, m;
    int                cl[6] = '{-3, 0, 1, 3, 6, 7};
    localparam dslas_cnt_t TB_PREGAP = 36'h6, TB_BETA = 36'h14, TB_CRSC = 36'hA;
    localparam dslas_cnt_t TB_PLL = 36'h3C, TB_SIL = 36'h10, TB_GLB = 36'h7D0, TB_PAY = 36'h32;
    dslas_link_if link ();

    dslas_central #(.P_CRSC(TB_CRSC), .P_PLL(TB_PLL), .P_SILENCE(TB_SIL), .P_BETA(TB_BETA),
        .P_GLOBAL(TB_GLB), .P_PAYLOAD(TB_PAY)) u_dslas_central (.core_clk_i, .reset_n_i, .ce_i,
        .start_i,
        .preact_done_i(pd_i), .tx_dbm_i(c_tx), .rx_est_dbm_i(c_rx), .pbo_req_i(c_rq),
        .rate_mult_i(rate), .converged_i(conv_i), .abnormal_i(ab_i), .framer_sync_i(fs_i),
        .four_wire_i(fw_i), .other_pair_done_i(opd_i), .user_bit_i(ub_i), .link(link.central),
        .state_o(c_st), .pbo_o(c_pbo), .far_pbo_o(c_fp), .data_mode_o(c_dm),
        .user_data_en_o(c_ue), .payload_valid_o(c_pv), .exception_o(c_ex));
    dslas_remote #(.P_PREGAP(TB_PREGAP), .P_BETA(TB_BETA), .P_PLL(TB_PLL), .P_SILENCE(TB_SIL),
        .P_GLOBAL(TB_GLB), .P_PAYLOAD(TB_PAY)) u_dslas_remote (.core_clk_i, .reset_n_i, .ce_i,
        .start_i,
        .preact_done_i(pd_i), .tx_dbm_i(r_tx), .rx_est_dbm_i(r_rx), .pbo_req_i(r_rq),
        .rate_mult_i(rate), .lock_i(lock_i), .abnormal_i(ab_i), .framer_sync_i(fs_i),
        .four_wire_i(fw_i), .other_pair_done_i(opd_i), .user_bit_i(ub_i), .link(link.remote),
        .state_o(r_st), .pbo_o(r_pbo), .far_pbo_o(r_fp), .data_mode_o(r_dm),
        .user_data_en_o(r_ue), .payload_valid_o(r_pv), .exception_o(r_ex));
    dslas_chk u_dslas_chk (.core_clk_i, .reset_n_i, .c_on(link.c_on), .c_bit(link.c_bit),
        .c_pbo(link.c_pbo), .r_on(link.r_on), .r_bit(link.r_bit), .r_pbo(link.r_pbo));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [4:0] exp_pbo(input int tx, input int rx, input int req);
        int d;
        d = tx - rx;
        d = (d > 6) ? 0 : (d < 1) ? 6 : 7 - d;
        return 5'((req > d) ? req : d);
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_st(input bit cen, input logic [2:0] st, output int n);
        n = 0;
        do begin
            @(posedge core_clk_i);
            #1;
            n++;
        end while (((cen ? c_st : r_st) !== st) && n < 3000);
        chk(8'(n < 3000), 8'h01);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        seed = 40;
        {reset_n_i, start_i, pd_i, ab_i, fs_i, fw_i, opd_i, ub_i, conv_i, lock_i} = '0;
        ce_i = 1'b1;
        {c_tx, c_rx, r_tx, r_rx, c_rq, r_rq, rate} = '0;
        for (int i = 0; i < 30; i++) begin
            m = i % 5;
            @(posedge core_clk_i);
            reset_n_i <= 1'b0;
            repeat (16) @(posedge core_clk_i);
            reset_n_i <= 1'b1;
            @(posedge core_clk_i);
            c_tx <= (i < 6) ? 8'sh0A : 8'(rnd() % 16);
            c_rx <= (i < 6) ? 8'(10 - cl[i]) : 8'(rnd() % 16);
            c_rq <= (i == 2) ? 5'h1F : 5'(rnd() % 9);
            r_tx <= 8'(rnd() % 16);
            r_rx <= 8'(rnd() % 16);
            r_rq <= 5'(rnd() % 9);
            rate <= (i < 2) ? 6'(12 + i) : 6'(3 + rnd() % 34);
            {fw_i, opd_i, ub_i} <= 3'(rnd());
            conv_i <= (m != 1);
            lock_i <= (m != 3);
            fs_i <= (m != 4);
            ce_i <= 1'b0;
            start_i <= 1'b1;
            #1;
            chk(8'({c_st, c_pbo}), 8'h06);
            @(posedge core_clk_i);
            ce_i <= 1'b1;
            #1;
            chk(8'({c_st, r_st}), 8'h00);
            @(posedge core_clk_i);
            start_i <= 1'b0;
            repeat (3) @(posedge core_clk_i);
            pd_i <= 1'b1;
            @(posedge core_clk_i);
            pd_i <= 1'b0;
            #1;
            u = (rate > 6'h0C) ? 20 : 40;
            chk(8'(c_pbo), 8'(exp_pbo(c_tx, c_rx, c_rq)));
            chk(8'(r_pbo), 8'(exp_pbo(r_tx, r_rx, r_rq)));
            chk(8'(c_fp), 8'(exp_pbo(r_tx, r_rx, r_rq)));
            chk(8'(r_fp), 8'(exp_pbo(c_tx, c_rx, c_rq)));
            wait_st(1'b0, 3'h2, t);
            if (m == 1) begin
                wait_st(1'b1, 3'h4, t);
                chk(8'({c_ex, link.c_on}), 8'h02);
            end else if (m == 3) begin
                wait_st(1'b0, 3'h4, t);
                chk(8'(r_ex), 8'h01);
            end else begin
                wait_st(1'b0, 3'h5, t);
                chk(8'(t <= 15 * u), 8'h01);
                wait_st(1'b1, 3'h5, t);
                chk(8'(c_dm & r_dm), 8'h01);
                if (m == 0) begin
                    repeat (31) @(posedge core_clk_i);
                    #1;
                    chk(8'({c_pv, r_pv, c_ue, r_ue}), 8'({2'b11, {2{!fw_i | opd_i}}}));
                    chk(8'({link.c_bit, link.r_bit}), 8'({2{ub_i & c_ue}}));
                end else if (m == 4) begin
                    wait_st(1'b1, 3'h4, t);
                    chk(8'(t inside {[48:52]}), 8'h01);
                end else begin
                    @(posedge core_clk_i);
                    ab_i <= 1'b1;
                    @(posedge core_clk_i);
                    ab_i <= 1'b0;
                    wait_st(1'b1, 3'h4, t);
                    chk(8'(t <= 2), 8'h01);
                    wait_st(1'b1, 3'h1, t);
                    chk(8'(t + 1 >= 16 && c_st === 3'h1), 8'h01);
                end
            end
        end
        conclude();
    end
endmodule // test_dsl_activation_sequencer
`default_nettype wire
